/* core/conv_ctrl_pkg.sv */
// Shared constants for the dual converter conversion-control logic.
package conv_ctrl_pkg;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int FULL_RESET_NS = 1200;
    localparam int FULL_RESET_CYC = (FULL_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int ACQ_NS = 480;
    localparam int ACQ_CYC = (ACQ_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SAMPLE_W = 16;
    localparam int MAX_SHIFT = 7;
    localparam int ACC_W = SAMPLE_W + MAX_SHIFT;
    localparam int CHANNELS_PER_SIDE = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] CHANNEL_OFFSET = 8'h04;
    localparam logic [7:0] RANGE_A_OFFSET = 8'h08;
    localparam logic [7:0] RANGE_B_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;

    // Config register fields
    localparam int CFG_OS_LSB = 0;
    localparam int CFG_BURST_BIT = 3;
    localparam int CFG_LAST_LSB = 4;
    // Channel register fields
    localparam int CHN_A_LSB = 0;
    localparam int CHN_B_LSB = 4;
    localparam int CHN_DIAG_BIT = 8;
    // Status register fields
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_SW_BIT = 1;
    localparam int STS_REF_BIT = 2;
    localparam int STS_OS_LSB = 3;

    // Range codes, shared by the range pins and the range registers
    localparam logic [1:0] RANGE_FROM_REG = 2'h0;
    localparam logic [1:0] RANGE_2V5 = 2'h1;
    localparam logic [1:0] RANGE_5V = 2'h2;
    localparam logic [1:0] RANGE_10V = 2'h3;

    localparam logic [6:0] CONFIG_RESET = 7'h00;
    localparam logic [8:0] CHANNEL_RESET = 9'h000;
    localparam logic [15:0] RANGE_RESET = 16'hFFFF;
endpackage

/* core/avg_if.sv */
// Control and data path between the sequencer and the sample averager.
`timescale 1ns/1ps
interface avg_if;
    import conv_ctrl_pkg::*;
    logic clear;
    logic add;
    logic [2:0] shift;
    logic signed [SAMPLE_W-1:0] sample_a;
    logic signed [SAMPLE_W-1:0] sample_b;
    logic signed [SAMPLE_W-1:0] mean_a;
    logic signed [SAMPLE_W-1:0] mean_b;
    modport ctrl (output clear, output add, output shift, output sample_a, output sample_b,
                  input mean_a, input mean_b);
    modport averager (input clear, input add, input shift, input sample_a, input sample_b,
                      output mean_a, output mean_b);
endinterface

/* core/sample_averager.sv */
// Signed accumulator and power-of-two divider for both converter sides.
`timescale 1ns/1ps
module sample_averager
    import conv_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    avg_if.averager av
);
    logic signed [ACC_W-1:0] acc_a_q;
    logic signed [ACC_W-1:0] acc_b_q;
    logic signed [ACC_W-1:0] acc_a_d;
    logic signed [ACC_W-1:0] acc_b_d;
    logic signed [ACC_W-1:0] shifted_a;
    logic signed [ACC_W-1:0] shifted_b;

    // Headroom of MAX_SHIFT bits keeps the largest ratio from overflowing
    assign acc_a_d = av.clear ? '0 : (av.add ? acc_a_q + ACC_W'(av.sample_a) : acc_a_q);
    assign acc_b_d = av.clear ? '0 : (av.add ? acc_b_q + ACC_W'(av.sample_b) : acc_b_q);
    // Arithmetic shift truncates toward minus infinity
    assign shifted_a = acc_a_q >>> av.shift;
    assign shifted_b = acc_b_q >>> av.shift;
    assign av.mean_a = shifted_a[SAMPLE_W-1:0];
    assign av.mean_b = shifted_b[SAMPLE_W-1:0];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_a_q <= '0;
            acc_b_q <= '0;
        end else begin
            acc_a_q <= acc_a_d;
            acc_b_q <= acc_b_d;
        end
    end
endmodule

/* core/conv_control.sv */
// Conversion control: mode latch, channel pairing, ranges, reset, oversampling.
// Notes on behaviour
// - Pin mode takes configuration from pins; register mode from registers.
// - Two simultaneous converters, eight channels each, sixteen inputs.
// - Supply diagnostic channel selectable only in register mode.
// - Pin mode samples A and B channels of one shared index.
// - Register mode pairs any A channel with any B channel.
// - Range pins 00 register, 01 2.5 V, 10 5 V, 11 10 V.
// - Register mode keeps an independent range per channel.
// - Results are 16-bit two's complement codes.
// - One code step is full-scale span over 65,536.
// - Ideal code transitions sit at half and one and a half steps.
// - Reference select high enables internal reference; low disables it.
// - After full reset the captured reference mode applies.
// - Reset low over 1.2 us enters shutdown; rising reset leaves.
// - Shutdown powers down and returns all registers to defaults.
// - Ratio from pins in pin mode, config field in register mode.
// - Pin mode captures oversampling pins at full reset release.
// - First sample on trigger edge, remaining samples on internal strobes.
// - Busy, acquisition and conversion lengthen with the ratio.
// - Burst finishes all oversamples of a channel before stepping.
// - Mode latched from range pins at full reset release; change needs full reset.
// - All register access refused in pin mode.
// - Reference select ignored after capture until next full reset.
`timescale 1ns/1ps
module conv_control
    import conv_ctrl_pkg::*;
#(
    // Log2 of the ratio for codes 7 down to 0
    parameter logic [23:0] OSR_LOG2_MAP = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
)(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic conversion_trigger,
    input wire logic [1:0] range_pins,
    input wire logic [2:0] channel_select_pins,
    input wire logic reference_source_select,
    input wire logic [2:0] oversample_ratio_pins,
    input wire logic adc_done,
    input wire logic [SAMPLE_W-1:0] adc_a_data,
    input wire logic [SAMPLE_W-1:0] adc_b_data,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    output logic busy,
    output logic sample_strobe,
    output logic [2:0] a_channel,
    output logic [2:0] b_channel,
    output logic diag_select,
    output logic [1:0] a_range,
    output logic [1:0] b_range,
    output logic ref_internal_enable,
    output logic shutdown,
    output logic software_mode,
    output logic result_valid,
    output logic [SAMPLE_W-1:0] result_a,
    output logic [SAMPLE_W-1:0] result_b
);
    typedef enum logic [1:0] {IDLE, ACQUIRE, CONVERT, FINISH} seq_state_type;

    localparam int PIN_W = 11;
    // Reset pin idles high; a low reset value here would fake a release edge
    localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(1) << (PIN_W - 1);
    localparam int LOW_CNT_W = $clog2(FULL_RESET_CYC + 1);
    localparam int ACQ_CNT_W = $clog2(ACQ_CYC + 1);

    avg_if av ();

    sample_averager averager_inst (
        .clock(clock),
        .rst_n(rst_n),
        .av(av)
    );

    // Two-stage synchroniser for every pin input
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;
    logic reset_sync;
    logic trigger_sync;
    logic [1:0] range_sync;
    logic [2:0] chsel_sync;
    logic reference_source_select_sync;
    logic [2:0] os_pins_sync;

    assign {reset_sync, trigger_sync, range_sync, chsel_sync, reference_source_select_sync, os_pins_sync}
        = pin_sync_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_meta_q <= PIN_IDLE;
            pin_sync_q <= PIN_IDLE;
        end else begin
            pin_meta_q <= {reset_pin, conversion_trigger, range_pins, channel_select_pins,
                           reference_source_select, oversample_ratio_pins};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Reset pin pulse measurement and shutdown
    logic reset_prev_q;
    logic trigger_prev_q;
    logic [LOW_CNT_W-1:0] low_cnt_q;
    logic shutdown_q;
    logic reset_rise;
    logic trigger_rise;
    logic long_low;

    assign reset_rise = reset_sync && !reset_prev_q;
    assign trigger_rise = trigger_sync && !trigger_prev_q;
    assign long_low = !reset_sync && (low_cnt_q == LOW_CNT_W'(FULL_RESET_CYC));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reset_prev_q <= 1'b1;
            trigger_prev_q <= 1'b0;
            low_cnt_q <= '0;
            // Power-up behaves as a held reset until the pin first rises
            shutdown_q <= 1'b1;
        end else begin
            reset_prev_q <= reset_sync;
            trigger_prev_q <= trigger_sync;
            if (reset_sync) begin
                low_cnt_q <= '0;
            end else if (!long_low) begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
            if (long_low) begin
                shutdown_q <= 1'b1;
            end else if (reset_rise) begin
                shutdown_q <= 1'b0;
            end
        end
    end

    // Straps captured only when leaving a full reset
    logic software_mode_q;
    logic ref_internal_q;
    logic [2:0] os_pins_latched_q;
    logic full_release;

    assign full_release = reset_rise && shutdown_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            software_mode_q <= 1'b0;
            ref_internal_q <= 1'b0;
            os_pins_latched_q <= '0;
        end else if (full_release) begin
            software_mode_q <= (range_sync == RANGE_FROM_REG);
            ref_internal_q <= reference_source_select_sync;
            os_pins_latched_q <= os_pins_sync;
        end
    end

    // Register file, cleared to defaults while shut down
    logic [6:0] config_q;
    logic [8:0] channel_q;
    logic [15:0] range_a_q;
    logic [15:0] range_b_q;
    logic reg_access_ok;
    logic wr_config;
    logic wr_channel;
    logic wr_range_a;
    logic wr_range_b;

    // Pin mode turns the whole register port off
    assign reg_access_ok = software_mode_q && !shutdown_q;
    assign wr_config = reg_write && reg_access_ok && (reg_addr == CONFIG_OFFSET);
    assign wr_channel = reg_write && reg_access_ok && (reg_addr == CHANNEL_OFFSET);
    assign wr_range_a = reg_write && reg_access_ok && (reg_addr == RANGE_A_OFFSET);
    assign wr_range_b = reg_write && reg_access_ok && (reg_addr == RANGE_B_OFFSET);

    always_ff @(posedge clock) begin
        if (!rst_n || shutdown_q) begin
            config_q <= CONFIG_RESET;
            channel_q <= CHANNEL_RESET;
            range_a_q <= RANGE_RESET;
            range_b_q <= RANGE_RESET;
        end else begin
            if (wr_config) begin
                config_q <= reg_wdata[6:0];
            end
            if (wr_channel) begin
                channel_q <= reg_wdata[8:0];
            end
            if (wr_range_a) begin
                range_a_q <= reg_wdata[15:0];
            end
            if (wr_range_b) begin
                range_b_q <= reg_wdata[15:0];
            end
        end
    end

    // Oversampling ratio selection
    logic [2:0] os_code;
    logic [2:0] os_shift;
    logic [MAX_SHIFT-1:0] last_sample;

    assign os_code = software_mode_q ? config_q[CFG_OS_LSB +: 3] : os_pins_latched_q;
    assign os_shift = OSR_LOG2_MAP[os_code*3 +: 3];
    assign last_sample = MAX_SHIFT'((8'h01 << os_shift) - 8'h01);

    // Sequencer
    seq_state_type state_q;
    seq_state_type state_d;
    logic [MAX_SHIFT-1:0] sample_cnt_q;
    logic [ACQ_CNT_W-1:0] acq_cnt_q;
    logic [2:0] a_idx_q;
    logic [2:0] b_idx_q;
    logic diag_q;
    logic burst_q;
    logic [2:0] burst_last_q;
    logic start;
    logic acq_done;
    logic set_done;
    logic burst_step;
    logic [2:0] a_start;
    logic [2:0] b_start;
    logic diag_start;

    // Partial and full reset both abort and hold off conversions
    assign start = (state_q == IDLE) && trigger_rise && reset_sync && !shutdown_q;
    assign acq_done = (acq_cnt_q == ACQ_CNT_W'(ACQ_CYC - 1));
    assign set_done = adc_done && (sample_cnt_q == last_sample);
    assign burst_step = burst_q && (a_idx_q != burst_last_q);
    assign a_start = software_mode_q ? channel_q[CHN_A_LSB +: 3] : chsel_sync;
    assign b_start = software_mode_q ? channel_q[CHN_B_LSB +: 3] : chsel_sync;
    assign diag_start = software_mode_q && channel_q[CHN_DIAG_BIT];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IDLE: begin
                if (start) begin
                    state_d = CONVERT;
                end
            end
            ACQUIRE: begin
                if (acq_done) begin
                    state_d = CONVERT;
                end
            end
            CONVERT: begin
                if (set_done) begin
                    state_d = FINISH;
                end else if (adc_done) begin
                    state_d = ACQUIRE;
                end
            end
            FINISH: begin
                state_d = burst_step ? ACQUIRE : IDLE;
            end
        endcase
    end

    assign av.clear = start || (state_q == FINISH);
    assign av.add = (state_q == CONVERT) && adc_done;
    assign av.shift = os_shift;
    assign av.sample_a = adc_a_data;
    assign av.sample_b = adc_b_data;

    always_ff @(posedge clock) begin
        if (!rst_n || !reset_sync) begin
            state_q <= IDLE;
            sample_cnt_q <= '0;
            acq_cnt_q <= '0;
            a_idx_q <= '0;
            b_idx_q <= '0;
            diag_q <= 1'b0;
            burst_q <= 1'b0;
            burst_last_q <= '0;
        end else begin
            state_q <= state_d;
            acq_cnt_q <= (state_q == ACQUIRE) ? acq_cnt_q + 1'b1 : '0;
            if (start) begin
                sample_cnt_q <= '0;
                a_idx_q <= a_start;
                b_idx_q <= b_start;
                diag_q <= diag_start;
                burst_q <= software_mode_q && config_q[CFG_BURST_BIT];
                burst_last_q <= config_q[CFG_LAST_LSB +: 3];
            end else if (state_q == CONVERT && adc_done) begin
                sample_cnt_q <= sample_cnt_q + 1'b1;
            end else if (state_q == FINISH) begin
                sample_cnt_q <= '0;
                if (burst_step) begin
                    // Burst steps A and B upward together from their own start indices
                    a_idx_q <= a_idx_q + 1'b1;
                    b_idx_q <= b_idx_q + 1'b1;
                end
            end
        end
    end

    // Outputs, all registered
    logic [1:0] a_range_d;
    logic [1:0] b_range_d;
    logic [2:0] a_cur;
    logic [2:0] b_cur;
    logic strobe_d;
    logic sts_hit;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] status_word;

    // Pins override registers for every channel unless both are low
    // Range follows the same index as the channel outputs, so both agree at the strobe
    assign a_cur = (state_q == IDLE) ? a_start : a_idx_q;
    assign b_cur = (state_q == IDLE) ? b_start : b_idx_q;
    assign a_range_d = (range_sync != RANGE_FROM_REG) ? range_sync
                                                      : range_a_q[a_cur*2 +: 2];
    assign b_range_d = (range_sync != RANGE_FROM_REG) ? range_sync
                                                      : range_b_q[b_cur*2 +: 2];
    assign strobe_d = start || ((state_q == ACQUIRE) && acq_done && reset_sync);

    assign status_word = DATA_W'({os_code, ref_internal_q, software_mode_q, busy});
    assign sts_hit = reg_addr == STATUS_OFFSET;
    assign rdata_d = !(reg_read && reg_access_ok) ? '0 :
                     (reg_addr == CONFIG_OFFSET) ? DATA_W'(config_q) :
                     (reg_addr == CHANNEL_OFFSET) ? DATA_W'(channel_q) :
                     (reg_addr == RANGE_A_OFFSET) ? DATA_W'(range_a_q) :
                     (reg_addr == RANGE_B_OFFSET) ? DATA_W'(range_b_q) :
                     sts_hit ? status_word : '0;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            busy <= 1'b0;
            sample_strobe <= 1'b0;
            a_channel <= '0;
            b_channel <= '0;
            diag_select <= 1'b0;
            a_range <= RANGE_10V;
            b_range <= RANGE_10V;
            ref_internal_enable <= 1'b0;
            shutdown <= 1'b1;
            software_mode <= 1'b0;
            result_valid <= 1'b0;
            result_a <= '0;
            result_b <= '0;
        end else begin
            reg_rdata <= rdata_d;
            busy <= (state_d != IDLE) && reset_sync;
            sample_strobe <= strobe_d;
            a_channel <= a_cur;
            b_channel <= b_cur;
            diag_select <= (state_q == IDLE) ? diag_start : diag_q;
            // Range code sets the code step: span over 65,536, mid-step thresholds
            a_range <= a_range_d;
            b_range <= b_range_d;
            ref_internal_enable <= ref_internal_q && !shutdown_q;
            shutdown <= shutdown_q;
            software_mode <= software_mode_q;
            result_valid <= (state_q == FINISH);
            if (state_q == FINISH) begin
                result_a <= av.mean_a;
                result_b <= av.mean_b;
            end
        end
    end
endmodule

/* dv/conv_control_properties.sv */
// Port-level assertions for the conversion-control block.
`timescale 1ns/1ps
module conv_control_properties
    import conv_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_read,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic busy,
    input wire logic sample_strobe,
    input wire logic [2:0] a_channel,
    input wire logic [2:0] b_channel,
    input wire logic diag_select,
    input wire logic ref_internal_enable,
    input wire logic shutdown,
    input wire logic software_mode,
    input wire logic adc_done,
    input wire logic result_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_strobe_pulse; sample_strobe |=> !sample_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_sw_status;
        reg_read && reg_addr == STATUS_OFFSET && software_mode && !shutdown
            |=> reg_rdata[STS_SW_BIT];
    endproperty
    a_sw_status: assert property (p_sw_status) else $error("mode bit not set");
    property p_pin_refuse; reg_read && !software_mode |=> reg_rdata == '0; endproperty
    a_pin_refuse: assert property (p_pin_refuse) else $error("pin mode read answered");
    property p_diag_hw; !software_mode |-> !diag_select; endproperty
    a_diag_hw: assert property (p_diag_hw) else $error("diag in pin mode");
    property p_hw_pair; sample_strobe && !software_mode |-> a_channel == b_channel; endproperty
    a_hw_pair: assert property (p_hw_pair) else $error("pin mode pair split");
    // Allows a short lag for the strap capture after wake-up
    property p_ref_hold; !shutdown [*3] |-> $stable(ref_internal_enable); endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference changed");
    property p_shut_ref; shutdown && $past(shutdown) |-> !ref_internal_enable; endproperty
    a_shut_ref: assert property (p_shut_ref) else $error("reference on in shutdown");
    property p_done_next;
        adc_done && busy |-> ##[1:8] (sample_strobe || result_valid || !busy);
    endproperty
    a_done_next: assert property (p_done_next) else $error("no strobe after sample");
    c_sw_conv: cover property (sample_strobe && software_mode);
    c_hw_result: cover property (result_valid && !software_mode);
    c_sw_read: cover property (reg_read && software_mode);
endmodule
bind conv_control conv_control_properties conv_control_properties_inst (
    .clock(clock), .rst_n(rst_n), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .busy(busy), .sample_strobe(sample_strobe),
    .a_channel(a_channel), .b_channel(b_channel), .diag_select(diag_select),
    .ref_internal_enable(ref_internal_enable), .shutdown(shutdown),
    .software_mode(software_mode), .adc_done(adc_done), .result_valid(result_valid));

/* dv/adc_core_model.sv */
// Behavioural converter core answering sample requests.
`timescale 1ns/1ps
module adc_core_model
    import conv_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic sample_strobe,
    input wire logic slow,
    input wire logic [SAMPLE_W-1:0] a_base,
    input wire logic [SAMPLE_W-1:0] b_base,
    output logic adc_done,
    output logic [SAMPLE_W-1:0] adc_a_data,
    output logic [SAMPLE_W-1:0] adc_b_data,
    output logic [31:0] strobe_count
);
    int wait_cnt = -1;
    initial begin
        adc_done = 1'b0;
        adc_a_data = 16'h0000;
        adc_b_data = 16'h0000;
        strobe_count = 32'h0;
    end
    // Data flips outside the done cycle so a stale sample never looks valid
    always @(posedge clock) begin
        adc_done <= 1'b0;
        adc_a_data <= ~adc_a_data;
        adc_b_data <= ~adc_b_data;
        if (sample_strobe) begin
            wait_cnt <= slow ? 8 : 1;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 0) begin
            adc_done <= 1'b1;
            adc_a_data <= a_base + strobe_count[15:0];
            adc_b_data <= b_base - strobe_count[15:0];
            strobe_count <= strobe_count + 32'h1;
            wait_cnt <= -1;
        end
    end
endmodule

/* dv/test_dual_adc_conversion_control.sv */
// Self-checking bench for the conversion-control block.
`timescale 1ns/1ps
module test_dual_adc_conversion_control;
    import conv_ctrl_pkg::*;
    // Wake-up wait shortened for both writes and conversions to keep the run short
    localparam int WAKE_CYC = 2400;
    logic clock, rst_n, reset_pin, trig, ref_sel, reg_write, reg_read, slow, diag;
    logic [1:0] rng_pins, a_range, b_range, rng_a, rng_b;
    logic [2:0] ch_pins, os_pins, a_channel, b_channel, ch_a, ch_b;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic busy, sample_strobe, diag_select, ref_on, shutdown, sw_mode, result_valid, adc_done;
    logic [SAMPLE_W-1:0] adc_a, adc_b, result_a, result_b, a_base, b_base;
    logic [31:0] scount, c0;
    int err_count, n_compared, n_str, bcyc, b_one;
    conv_control conv_control_inst (
        .clock(clock), .rst_n(rst_n), .reset_pin(reset_pin), .conversion_trigger(trig),
        .range_pins(rng_pins), .channel_select_pins(ch_pins), .reference_source_select(ref_sel),
        .oversample_ratio_pins(os_pins), .adc_done(adc_done), .adc_a_data(adc_a),
        .adc_b_data(adc_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy), .sample_strobe(sample_strobe),
        .a_channel(a_channel), .b_channel(b_channel), .diag_select(diag_select),
        .a_range(a_range), .b_range(b_range), .ref_internal_enable(ref_on),
        .shutdown(shutdown), .software_mode(sw_mode), .result_valid(result_valid),
        .result_a(result_a), .result_b(result_b));
    adc_core_model adc_core_model_inst (.clock(clock), .sample_strobe(sample_strobe),
        .slow(slow), .a_base(a_base), .b_base(b_base), .adc_done(adc_done),
        .adc_a_data(adc_a), .adc_b_data(adc_b), .strobe_count(scount));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic full_reset(input logic [1:0] rp, input logic rs, input logic [2:0] os);
        @(posedge clock);
        rng_pins <= rp;
        ref_sel <= rs;
        os_pins <= os;
        reset_pin <= 1'b0;
        repeat (FULL_RESET_CYC + 4) @(posedge clock);
        #1 chk(32'(shutdown), 32'h1);
        @(posedge clock);
        reset_pin <= 1'b1;
        repeat (WAKE_CYC) @(posedge clock);
        #1 chk(32'(shutdown), 32'h0);
        chk(32'(ref_on), 32'(rs));
    endtask
    task automatic convert();
        int g;
        c0 = scount;
        n_str = 0;
        bcyc = 0;
        g = 0;
        @(posedge clock);
        trig <= 1'b1;
        repeat (2) @(posedge clock);
        // The first strobe rises only on the fourth edge, so look from there on
        while (result_valid !== 1'b1 && g < 3000) begin
            @(posedge clock);
            trig <= 1'b0;
            #1 g++;
            bcyc += int'(busy === 1'b1);
            if (sample_strobe === 1'b1) begin
                n_str++;
                ch_a = a_channel;
                ch_b = b_channel;
                rng_a = a_range;
                rng_b = b_range;
                diag = diag_select;
            end
        end
        chk(32'(g < 3000), 32'h1);
    endtask
    initial begin
        #(100 * 60000);
        err_count++;
        end_of_test();
    end
    initial begin
        err_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        reset_pin = 1'b1;
        trig = 1'b0;
        ref_sel = 1'b0;
        rng_pins = 2'h0;
        ch_pins = 3'h0;
        os_pins = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        slow = 1'b1;
        a_base = 16'h1234;
        b_base = 16'h8010;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1 chk(32'(shutdown), 32'h1);
        chk(32'(a_range), 32'h3);
        rd(STATUS_OFFSET);
        chk(rd_val, 32'h0);
        repeat (3) @(posedge clock);
        #1 chk(32'(shutdown), 32'h1);
        full_reset(2'h0, 1'b1, 3'h5);
        chk(32'(sw_mode), 32'h1);
        ref_sel <= 1'b0;
        rd(STATUS_OFFSET);
        chk(rd_val, 32'h6);
        chk(32'(ref_on), 32'h1);
        wr(CHANNEL_OFFSET, 32'h163);
        rd(CHANNEL_OFFSET);
        chk(rd_val, 32'h163);
        rd(8'h20);
        chk(rd_val, 32'h0);
        wr(RANGE_A_OFFSET, 32'hFF7F);
        wr(RANGE_B_OFFSET, 32'hEFFF);
        rd(RANGE_A_OFFSET);
        chk(rd_val, 32'hFF7F);
        convert();
        b_one = bcyc;
        chk({26'h0, ch_a, ch_b}, 32'h1E);
        chk({28'h0, rng_a, rng_b}, 32'h6);
        chk(32'(diag), 32'h1);
        chk(32'(result_a), 32'(a_base + c0[15:0]));
        chk(32'(result_b), 32'(b_base - c0[15:0]));
        wr(CONFIG_OFFSET, 32'h48);
        convert();
        chk(32'(busy), 32'h1);
        convert();
        chk({26'h0, ch_a, ch_b}, 32'h27);
        wr(CONFIG_OFFSET, 32'h3);
        convert();
        chk(32'(n_str), 32'h8);
        chk(32'(result_a), 32'(a_base + c0[15:0] + 16'h3));
        chk(32'(result_b), 32'(b_base - c0[15:0] - 16'h4));
        chk(32'(bcyc > 4 * b_one), 32'h1);
        @(posedge clock);
        trig <= 1'b1;
        repeat (12) @(posedge clock);
        trig <= 1'b0;
        reset_pin <= 1'b0;
        #1 chk(32'(busy), 32'h1);
        repeat (3) @(posedge clock);
        reset_pin <= 1'b1;
        repeat (8) @(posedge clock);
        #1 chk(32'(busy), 32'h0);
        rd(CHANNEL_OFFSET);
        chk(rd_val, 32'h163);
        full_reset(2'h1, 1'b0, 3'h1);
        chk(32'(sw_mode), 32'h0);
        rd(CHANNEL_OFFSET);
        chk(rd_val, 32'h0);
        slow <= 1'b0;
        ch_pins <= 3'h5;
        convert();
        chk({26'h0, ch_a, ch_b}, 32'h2D);
        chk({28'h0, rng_a, rng_b}, 32'h5);
        chk(32'(n_str), 32'h2);
        chk(32'(result_b), 32'(b_base - c0[15:0] - 16'h1));
        os_pins <= 3'h3;
        for (int r = 2; r < 4; r++) begin
            rng_pins <= 2'(r);
            repeat (1200) @(posedge clock);
            convert();
            chk(32'(rng_a), 32'(r));
            chk(32'(n_str), 32'h2);
        end
        full_reset(2'h0, 1'b1, 3'h0);
        rd(RANGE_A_OFFSET);
        chk(rd_val, 32'hFFFF);
        rd(CHANNEL_OFFSET);
        chk(rd_val, 32'h0);
        end_of_test();
    end
endmodule
